// ===== bench/pbc_ctrl_bench.sv
// Self-checking bench for the second loop's input select and holdover control
`timescale 1ns/10ps
`default_nettype none
module pbc_ctrl_bench;
	import pbc_pkg::*;

	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic reg_rvalid;
	logic [1:0] sel_pins = 2'h0;
	logic [3:0] signal_loss_alarm = 4'h0;
	logic [3:0] off_frequency_alarm = 4'h0;
	logic loop_locked = 1'b1;
	logic soft_reset_all = 1'b0;
	logic [1:0] active_input_report;
	logic hold_state, freerun_state, quick_acquire_active_flag, history_valid_flag, phase_buildout_enable;
	logic [9:0] phase_measure_threshold;
	logic [47:0] hold_exit_bw_applied;
	logic bandwidth_apply_pulse;
	logic [7:0] exp_q[$];
	logic [7:0] msk_q[$];
	logic [7:0] mon_m;
	logic [47:0] bw;
	logic [7:0] d;
	integer seed = 32'h03af_ce23;
	int mismatches = 0;
	int samples_checked = 0;

	// Free-running system clock, 8 ns period
	always #4 clk_sys = ~clk_sys;

	pbc_ctrl #(.HIST_DELAY(5'h00)) u_dut (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid),
		.sel_pins(sel_pins),
		.signal_loss_alarm(signal_loss_alarm),
		.off_frequency_alarm(off_frequency_alarm),
		.loop_locked(loop_locked),
		.soft_reset_all(soft_reset_all),
		.active_input_report(active_input_report),
		.hold_state(hold_state),
		.freerun_state(freerun_state),
		.quick_acquire_active_flag(quick_acquire_active_flag),
		.history_valid_flag(history_valid_flag),
		.phase_buildout_enable(phase_buildout_enable),
		.phase_measure_threshold(phase_measure_threshold),
		.hold_exit_bw_applied(hold_exit_bw_applied),
		.bandwidth_apply_pulse(bandwidth_apply_pulse)
	);

	// ----------------------------------------
	// Bus tasks and comparison
	// ----------------------------------------
	// Inputs always move 1 ns after the edge so the design samples settled values
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc

	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		cyc(1);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = v;
		cyc(1);
		reg_wr = 1'b0;
	endtask : wr

	// Expected value is queued now and compared when the read data returns
	task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [7:0] m);
		cyc(1);
		reg_rd = 1'b1;
		reg_addr = a;
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		cyc(1);
		reg_rd = 1'b0;
	endtask : rd

	task automatic chk(input logic [47:0] got, input logic [47:0] e);
		samples_checked++;
		if (got !== e) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, e);
		end
	endtask : chk

	task automatic step(input logic [3:0] l, input logic [3:0] o, input logic [7:0] m, input logic [1:0] a);
		signal_loss_alarm = l;
		off_frequency_alarm = o;
		wr(16'h0537, m);
		cyc(5);
		chk(active_input_report, a);
		rd(PBC_OFS_ACTIVE, {a, 6'h00}, 8'hc0);
	endtask : step

	task automatic do_reset();
		resetn = 1'b0;
		cyc(4);
		resetn = 1'b1;
	endtask : do_reset

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test

	// Read monitor samples on the falling edge, away from the design's updates
	always @(negedge clk_sys) begin
		if (reg_rvalid === 1'b1) begin
			if (exp_q.size() == 0) begin
				chk(48'(reg_rdata), 48'hffff_ffff_ffff);
			end else begin
				mon_m = msk_q.pop_front();
				chk(48'(reg_rdata & mon_m), 48'(exp_q.pop_front()));
			end
		end
	end

	// Cuts a hang short well past the expected run of about a thousand cycles
	initial begin
		#(8 * 20000);
		mismatches++;
		end_of_test();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		do_reset();
		chk({hold_state, freerun_state}, 2'b01);
		// Reset values, then random data read back through the writable bits
		for (int i = 0; i < PBC_NUM_REGS; i++) begin
			rd(PBC_REG_OFS[i], PBC_REG_RST[i], 8'hff);
			d = $random(seed);
			if (PBC_REG_OFS[i] == 16'h052c) d[3] = 1'b1;
			if (PBC_REG_OFS[i] == 16'h053a) d[1:0] = 2'h2;
			wr(PBC_REG_OFS[i], d);
			rd(PBC_REG_OFS[i], d & PBC_REG_MASK[i], 8'hff);
		end
		wr(PBC_OFS_HIST_DELAY, 8'hff);
		rd(PBC_OFS_HIST_DELAY, 8'h00, 8'h1f);
		rd(16'h0600, 8'h00, 8'hff);
		rd(PBC_OFS_BW_APPLY, 8'h00, 8'hff);
		$display("test registers done");
		do_reset();
		// Fastlock forced, then automatic while unlocked
		cyc(100);
		rd(PBC_OFS_HIST_STATUS, 8'h02, 8'h06);
		wr(16'h052b, 8'h02);
		cyc(5);
		chk(quick_acquire_active_flag, 1'b1);
		rd(PBC_OFS_HIST_STATUS, 8'h04, 8'h04);
		wr(16'h052b, 8'h01);
		cyc(5);
		chk(quick_acquire_active_flag, 1'b0);
		loop_locked = 1'b0;
		cyc(5);
		chk(quick_acquire_active_flag, 1'b1);
		wr(16'h052b, 8'h00);
		cyc(5);
		chk(quick_acquire_active_flag, 1'b0);
		$display("test fastlock done");
		// Forced holdover and its exit bandwidth, both settings of the exit bit
		for (int b = 0; b < 2; b++) begin
			loop_locked = 1'b0;
			wr(16'h052c, b ? 8'h18 : 8'h08);
			wr(16'h0535, 8'h01);
			cyc(3);
			chk({hold_state, freerun_state}, 2'b10);
			wr(16'h0535, 8'h00);
			cyc(5);
			chk({hold_state, quick_acquire_active_flag}, {1'b0, b == 0});
			loop_locked = 1'b1;
			cyc(5);
			chk(quick_acquire_active_flag, 1'b0);
			cyc(100);
		end
		signal_loss_alarm = 4'h1;
		cyc(5);
		chk(hold_state, 1'b1);
		wr(16'h0537, 8'h01);
		cyc(5);
		chk(hold_state, 1'b0);
		signal_loss_alarm = 4'h0;
		$display("test holdover done");
		// Automatic selection by rank, alarm and mask
		wr(16'h0538, 8'h12);
		wr(16'h0539, 8'h03);
		wr(16'h0536, 8'h02);
		step(4'h0, 4'h0, 8'h00, 2'h1);
		step(4'h2, 4'h0, 8'h00, 2'h0);
		step(4'h2, 4'h0, 8'h02, 2'h1);
		step(4'h0, 4'h2, 8'h00, 2'h0);
		step(4'h0, 4'h2, 8'h20, 2'h1);
		wr(16'h0536, 8'h01);
		step(4'h2, 4'h0, 8'h00, 2'h0);
		step(4'h0, 4'h0, 8'h00, 2'h0);
		// Manual choice by register, reserved code, then by pins
		wr(16'h0536, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr(16'h052a, 8'(c * 2 + 1));
			cyc(5);
			rd(PBC_OFS_ACTIVE, 8'(c << 6), 8'hc0);
		end
		wr(16'h052a, 8'h09);
		cyc(5);
		rd(PBC_OFS_ACTIVE, 8'hc0, 8'hc0);
		wr(16'h052a, 8'h00);
		for (int p = 0; p < 4; p++) begin
			sel_pins = 2'(p);
			cyc(6);
			rd(PBC_OFS_ACTIVE, 8'(p << 6), 8'hc0);
		end
		$display("test selection done");
		// Window of 7 ticks plus 1 delay tick is 272 cycles after a switch
		wr(16'h052e, 8'h03);
		sel_pins = 2'h0;
		cyc(200);
		rd(PBC_OFS_HIST_STATUS, 8'h00, 8'h02);
		chk(history_valid_flag, 1'b0);
		cyc(150);
		rd(PBC_OFS_HIST_STATUS, 8'h02, 8'h02);
		chk(history_valid_flag, 1'b1);
		$display("test history done");
		// Build-out bit and split threshold
		d = $random(seed);
		wr(16'h0536, {5'h00, d[2], 2'h0});
		wr(16'h053b, d);
		wr(16'h053c, ~d);
		cyc(2);
		chk(phase_buildout_enable, d[2]);
		chk(phase_measure_threshold, {~d[1:0], d});
		// Exit bandwidth stays unapplied until the strobe
		for (int k = 0; k < 6; k++) begin
			d = $random(seed);
			bw[8 * k +: 8] = {2'h0, d[5:0]};
			wr(16'h059d + 16'(k), d);
		end
		chk(hold_exit_bw_applied, 48'h0);
		wr(PBC_OFS_BW_APPLY, 8'h01);
		chk({bandwidth_apply_pulse, hold_exit_bw_applied}, {1'b1, bw});
		cyc(1);
		chk(bandwidth_apply_pulse, 1'b0);
		wr(16'h059d, 8'hff);
		soft_reset_all = 1'b1;
		cyc(1);
		soft_reset_all = 1'b0;
		cyc(1);
		chk(hold_exit_bw_applied[7:0], 8'h3f);
		$display("test bandwidth done");
		cyc(5);
		chk(exp_q.size(), 0);
		end_of_test();
	end

endmodule : pbc_ctrl_bench
`default_nettype wire

// ===== rtl/pbc_ctrl.sv
// Input selection, fastlock and holdover control for the second loop
`timescale 1ns/10ps
`default_nettype none

// Operation
// RULE1 - Bits 3:1 pick input 0-3 manually; bit 0 picks pins or register
// RULE2 - Auto fastlock enable uses fast bandwidth while unlocked, unless manual fastlock set
// RULE3 - Manual fastlock bit forces fast bandwidth regardless of lock
// RULE4 - Software keeps holdover ramp bypass bit set in normal operation
// RULE5 - Leaving holdover uses fast bandwidth if exit bit is 0, else normal
// RULE6 - History averages over ((2^LEN)-1) times 268 ns
// RULE7 - Averaging window pushed back by (2^DELAY) times 268 ns on holdover entry
// RULE8 - Force holdover bit puts loop into holdover unconditionally; code enters free-run instead while history is not valid
// RULE9 - Switching mode: manual, automatic non-revertive, automatic revertive
// RULE10 - Switch control bit 2 turns phase build-out on for hitless switching
// RULE11 - Mask bit n removes input n loss-of-signal alarm from selection
// RULE12 - Mask bit n+4 removes input n off-frequency alarm from selection
// RULE13 - Unmasked alarms also drive holdover entry
// RULE14 - Each input has a 3-bit priority, 0 none, 1 to 4 ranks
// RULE15 - Software leaves hitless mode field at 2
// RULE16 - Phase threshold is 10 bits split low byte and bits 9:8
// RULE17 - History valid reads 1 when holdover is possible, else free-run
// RULE18 - History accumulation stops in holdover or free-run
// RULE19 - Valid input again clears history and restarts accumulation
// RULE20 - Status bit 2 reads 1 while fast bandwidth is used
// RULE21 - Bandwidth parameters take effect only on apply strobe or full soft reset
// RULE22 - Active input field bits 7:6 reports the input in use
module pbc_ctrl #(
	parameter logic [4:0] HIST_DELAY = 5'h00
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic [1:0] sel_pins,
	input wire logic [3:0] signal_loss_alarm,
	input wire logic [3:0] off_frequency_alarm,
	input wire logic loop_locked,
	input wire logic soft_reset_all,
	output logic [1:0] active_input_report,
	output logic hold_state,
	output logic freerun_state,
	output logic quick_acquire_active_flag,
	output logic history_valid_flag,
	output logic phase_buildout_enable,
	output logic [9:0] phase_measure_threshold,
	output logic [8*pbc_pkg::PBC_EXIT_BW_REGS-1:0] hold_exit_bw_applied,
	output logic bandwidth_apply_pulse
);
	import pbc_pkg::*;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [10:0] sync_meta;
	logic [10:0] sync_out;
	logic [1:0] pins_s;
	logic [3:0] los_s;
	logic [3:0] oof_s;
	logic lock_s;

	// Pins and alarms are asynchronous to clk_sys
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			sync_meta <= 11'h000;
			sync_out <= 11'h000;
		end else begin
			sync_meta <= {loop_locked, off_frequency_alarm, signal_loss_alarm, sel_pins};
			sync_out <= sync_meta;
		end
	end
	assign {lock_s, oof_s, los_s, pins_s} = sync_out;

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [7:0] regs [PBC_NUM_REGS];
	logic [7:0] next_regs [PBC_NUM_REGS];
	logic bw_strobe;

	// Writes keep only implemented bits so reserved bits read as zero
	always_comb begin
		for (int i = 0; i < PBC_NUM_REGS; i++) begin
			next_regs[i] = regs[i];
			if (reg_wr && reg_addr == PBC_REG_OFS[i]) begin
				next_regs[i] = reg_wdata & PBC_REG_MASK[i];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < PBC_NUM_REGS; i++) begin
			if (!resetn) begin
				regs[i] <= PBC_REG_RST[i];
			end else begin
				regs[i] <= next_regs[i];
			end
		end
	end

	// Self-clearing apply bit: never stored, only pulses
	assign bw_strobe = reg_wr && reg_addr == PBC_OFS_BW_APPLY && reg_wdata[PBC_BW_APPLY_BIT]; // RULE21

	// Field views
	logic sel_by_reg, auto_en, forced_fl, exit_bw_choice, force_hold_state;
	logic [2:0] manual_input_choice;
	logic [4:0] hist_len;
	logic [1:0] input_switching_mode;
	logic [3:0] signal_loss_alarm_mask, off_frequency_alarm_mask;
	logic [2:0] rank [4];

	assign sel_by_reg = regs[PBC_IX_INSEL][PBC_INSEL_REGCTRL_BIT]; // RULE1
	assign manual_input_choice = regs[PBC_IX_INSEL][PBC_INSEL_CHOICE_LSB +: 3]; // RULE1
	assign auto_en = regs[PBC_IX_FASTLOCK][PBC_FL_AUTO_BIT];
	assign forced_fl = regs[PBC_IX_FASTLOCK][PBC_FL_MAN_BIT];
	assign exit_bw_choice = regs[PBC_IX_HOLD][PBC_HOLD_EXIT_BW_BIT];
	assign hist_len = regs[PBC_IX_HIST_LEN][4:0];
	assign force_hold_state = regs[PBC_IX_FORCE_HOLD][PBC_FORCE_HOLD_BIT];
	assign input_switching_mode = regs[PBC_IX_SWITCH][1:0];
	assign signal_loss_alarm_mask = regs[PBC_IX_MASKS][3:0];
	assign off_frequency_alarm_mask = regs[PBC_IX_MASKS][PBC_OOF_MASK_LSB +: 4];
	assign rank[0] = regs[PBC_IX_PRIO01][2:0]; // RULE14
	assign rank[1] = regs[PBC_IX_PRIO01][PBC_PRIO_HI_LSB +: 3]; // RULE14
	assign rank[2] = regs[PBC_IX_PRIO23][2:0]; // RULE14
	assign rank[3] = regs[PBC_IX_PRIO23][PBC_PRIO_HI_LSB +: 3]; // RULE14

	// ----------------------------------------
	// Input qualification and choice
	// ----------------------------------------
	logic [3:0] qualified;
	logic best_ok;
	logic [1:0] best_in;
	logic [2:0] best_rank;
	logic [1:0] want_in;
	logic want_ok;

	// Masked alarms are ignored; an unmasked one disqualifies the input
	assign qualified = ~(los_s & ~signal_loss_alarm_mask) & ~(oof_s & ~off_frequency_alarm_mask); // RULE11 RULE12

	// Lowest nonzero code wins; ties go to the lower input; reserved codes never win
	always_comb begin
		best_ok = 1'b0;
		best_in = 2'h0;
		best_rank = PBC_PRIO_WORST;
		for (int n = 0; n < 4; n++) begin
			if (qualified[n] && rank[n] >= PBC_PRIO_BEST && rank[n] <= PBC_PRIO_WORST
					&& (!best_ok || rank[n] < best_rank)) begin // RULE14
				best_ok = 1'b1;
				best_in = n[1:0];
				best_rank = rank[n];
			end
		end
	end

	// Target input per switching mode; reserved codes hold the current input
	always_comb begin
		want_in = active_input_report;
		case (input_switching_mode) // RULE9
			PBC_MODE_MANUAL: begin
				if (!sel_by_reg) begin
					want_in = pins_s;
				end else if (!manual_input_choice[2]) begin
					want_in = manual_input_choice[1:0]; // RULE1
				end
			end
			PBC_MODE_NONREV: begin
				if (!qualified[active_input_report] && best_ok) begin
					want_in = best_in;
				end
			end
			PBC_MODE_REV: begin
				if (best_ok) begin
					want_in = best_in;
				end
			end
			default: begin
				want_in = active_input_report;
			end
		endcase
	end
	assign want_ok = qualified[want_in]; // RULE13

	// ----------------------------------------
	// Loop state, history and fastlock
	// ----------------------------------------
	pbc_state_t state;
	pbc_state_t next_state;
	logic [1:0] next_active;
	logic [5:0] tick_cnt, next_tick_cnt;
	logic [31:0] hist_cnt, next_hist_cnt;
	logic [32:0] hist_need;
	logic next_valid, exit_fast, next_exit_fast, next_fl, tick;

	// One tick per 268 ns history quantum, rounded up to whole cycles
	assign tick = tick_cnt == 6'(PBC_HIST_TICK_CYC - 1);
	// Span needed: the averaging window plus the pushed-back delay
	assign hist_need = 33'((33'h1 << hist_len) - 33'h1) + 33'(33'h1 << HIST_DELAY); // RULE6 RULE7

	always_comb begin
		next_state = state;
		next_active = active_input_report;
		next_tick_cnt = tick ? 6'h00 : tick_cnt + 6'h01;
		next_hist_cnt = hist_cnt;
		next_exit_fast = exit_fast;
		case (state)
			PBC_ST_TRACK: begin
				if (force_hold_state || !want_ok) begin // RULE8 RULE13
					next_state = history_valid_flag ? PBC_ST_HOLD : PBC_ST_FREERUN; // RULE17
				end else if (want_in != active_input_report) begin
					next_active = want_in;
					next_hist_cnt = 32'h0000_0000; // RULE19
				end else if (tick && hist_cnt != 32'hffff_ffff) begin
					next_hist_cnt = hist_cnt + 32'h0000_0001;
				end
			end
			PBC_ST_HOLD, PBC_ST_FREERUN: begin
				// Accumulation frozen here
				if (!force_hold_state && want_ok) begin // RULE18
					next_state = PBC_ST_TRACK;
					next_active = want_in;
					next_hist_cnt = 32'h0000_0000; // RULE19
					if (state == PBC_ST_HOLD && !exit_bw_choice) begin
						next_exit_fast = 1'b1; // RULE5
					end
				end
			end
			default: begin
				next_state = PBC_ST_FREERUN;
			end
		endcase
		// Exit fastlock ends once locked in tracking; it is only ever set while leaving holdover
		if (exit_fast && lock_s && state == PBC_ST_TRACK) begin
			next_exit_fast = 1'b0;
		end
		next_valid = {1'b0, next_hist_cnt} >= hist_need; // RULE17
		next_fl = forced_fl || (auto_en && !lock_s) || next_exit_fast; // RULE2 RULE3 RULE5
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state <= PBC_ST_FREERUN;
			active_input_report <= 2'h0;
			tick_cnt <= 6'h00;
			hist_cnt <= 32'h0000_0000;
			history_valid_flag <= 1'b0;
			exit_fast <= 1'b0;
			quick_acquire_active_flag <= 1'b0;
			hold_state <= 1'b0;
			freerun_state <= 1'b1;
		end else begin
			state <= next_state;
			active_input_report <= next_active; // RULE22
			tick_cnt <= next_tick_cnt;
			hist_cnt <= next_hist_cnt;
			history_valid_flag <= next_valid;
			exit_fast <= next_exit_fast;
			quick_acquire_active_flag <= next_fl; // RULE20
			hold_state <= next_state == PBC_ST_HOLD;
			freerun_state <= next_state == PBC_ST_FREERUN;
		end
	end

	// ----------------------------------------
	// Config outputs and bandwidth apply
	// ----------------------------------------
	logic [8*PBC_EXIT_BW_REGS-1:0] next_bw;

	// Exit bandwidth copies only on the apply strobe or full soft reset
	always_comb begin
		next_bw = hold_exit_bw_applied;
		if (bw_strobe || soft_reset_all) begin
			for (int k = 0; k < PBC_EXIT_BW_REGS; k++) begin
				next_bw[8*k +: 8] = regs[PBC_IX_EXIT_BW0 + k]; // RULE21
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			hold_exit_bw_applied <= '0;
			bandwidth_apply_pulse <= 1'b0;
			phase_buildout_enable <= 1'b0;
			phase_measure_threshold <= 10'h000;
		end else begin
			hold_exit_bw_applied <= next_bw;
			bandwidth_apply_pulse <= bw_strobe || soft_reset_all; // RULE21
			phase_buildout_enable <= regs[PBC_IX_SWITCH][PBC_PBO_BIT]; // RULE10
			phase_measure_threshold <= {regs[PBC_IX_THR_HI][1:0], regs[PBC_IX_THR_LO]}; // RULE16
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic [7:0] next_rdata;

	// Unmapped addresses read zero
	always_comb begin
		next_rdata = 8'h00;
		for (int i = 0; i < PBC_NUM_REGS; i++) begin
			if (reg_addr == PBC_REG_OFS[i]) begin
				next_rdata = regs[i];
			end
		end
		if (reg_addr == PBC_OFS_ACTIVE) begin
			next_rdata = 8'(active_input_report) << PBC_ACTIVE_LSB; // RULE22
		end
		if (reg_addr == PBC_OFS_HIST_DELAY) begin
			next_rdata = {3'h0, HIST_DELAY};
		end
		if (reg_addr == PBC_OFS_HIST_STATUS) begin
			next_rdata = (8'(quick_acquire_active_flag) << PBC_ST_FASTLOCK_BIT)
				| (8'(history_valid_flag) << PBC_ST_VALID_BIT); // RULE17 RULE20
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rdata <= reg_rd ? next_rdata : reg_rdata;
			reg_rvalid <= reg_rd;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	a_force_hold_entry: assert property (state == PBC_ST_TRACK && force_hold_state |=> state != PBC_ST_TRACK) // RULE8
		else $error("forced holdover not entered");
	a_manual_fastlock: assert property (forced_fl |=> quick_acquire_active_flag) // RULE3
		else $error("manual fastlock not applied");
	a_auto_fastlock: assert property (!forced_fl && auto_en && !lock_s |=> quick_acquire_active_flag) // RULE2
		else $error("auto fastlock not applied while unlocked");
	a_fastlock_off: assert property (!forced_fl && !auto_en && !exit_fast && !next_exit_fast
			|=> !quick_acquire_active_flag) // RULE2
		else $error("fastlock used with no cause");
	a_hist_frozen: assert property (state != PBC_ST_TRACK ##1 state != PBC_ST_TRACK
			|-> hist_cnt == $past(hist_cnt)) // RULE18
		else $error("history grew outside tracking");
	a_hist_restart: assert property (state != PBC_ST_TRACK && next_state == PBC_ST_TRACK
			|=> hist_cnt == 32'h0000_0000 && !history_valid_flag) // RULE19
		else $error("history not cleared on return");
	a_exit_fast_bw: assert property (state == PBC_ST_HOLD && next_state == PBC_ST_TRACK && !exit_bw_choice
			|=> quick_acquire_active_flag) // RULE5
		else $error("fast bandwidth not used on holdover exit");
	a_bw_apply: assert property (bw_strobe |=> bandwidth_apply_pulse
			&& hold_exit_bw_applied == {$past(regs[30]), $past(regs[29]), $past(regs[28]),
			$past(regs[27]), $past(regs[26]), $past(regs[25])}) // RULE21
		else $error("exit bandwidth not applied");
	a_bw_held: assert property (!bw_strobe && !soft_reset_all |=> $stable(hold_exit_bw_applied)) // RULE21
		else $error("exit bandwidth changed without apply");
	a_alarm_leaves: assert property (state == PBC_ST_TRACK && !qualified[active_input_report]
			|=> state != PBC_ST_TRACK || active_input_report != $past(active_input_report)) // RULE13
		else $error("disqualified input kept in use");
	a_status_read: assert property (reg_rd && reg_addr == PBC_OFS_HIST_STATUS
			|=> reg_rvalid && reg_rdata[PBC_ST_FASTLOCK_BIT] == $past(quick_acquire_active_flag)) // RULE20
		else $error("fastlock status misread");

endmodule : pbc_ctrl
`default_nettype wire

// ===== rtl/pbc_pkg.sv
// Constants for the second loop's input select and holdover control block
package pbc_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int PBC_NUM_REGS = 32;
	localparam logic [15:0] PBC_OFS_ACTIVE = 16'h0507;
	localparam logic [15:0] PBC_OFS_BW_APPLY = 16'h0514;
	localparam logic [15:0] PBC_OFS_HIST_DELAY = 16'h052f;
	localparam logic [15:0] PBC_OFS_HIST_STATUS = 16'h053f;
	// Storable registers: offset, writable bits, reset value
	localparam logic [15:0] PBC_REG_OFS [PBC_NUM_REGS] = '{
		16'h052a, 16'h052b, 16'h052c, 16'h052e, 16'h0531, 16'h0532, 16'h0533, 16'h0534,
		16'h0535, 16'h0536, 16'h0537, 16'h0538, 16'h0539, 16'h053a, 16'h053b, 16'h053c,
		16'h053d, 16'h053e, 16'h0542, 16'h0543, 16'h0544, 16'h0545, 16'h0588, 16'h0589,
		16'h059b, 16'h059d, 16'h059e, 16'h059f, 16'h05a0, 16'h05a1, 16'h05a2, 16'h05a6};
	localparam logic [7:0] PBC_REG_MASK [PBC_NUM_REGS] = '{
		8'h0f, 8'h03, 8'hf9, 8'h1f, 8'h1f, 8'hff, 8'hff, 8'hff,
		8'h01, 8'h07, 8'hff, 8'h77, 8'h77, 8'h0f, 8'hff, 8'h03,
		8'h1f, 8'h1f, 8'hff, 8'hff, 8'h03, 8'h02, 8'h0f, 8'hff,
		8'hf6, 8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h0f};
	localparam logic [7:0] PBC_REG_RST [PBC_NUM_REGS] = '{
		8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	// Indexes of the storable registers the logic reads
	localparam int PBC_IX_INSEL = 0;
	localparam int PBC_IX_FASTLOCK = 1;
	localparam int PBC_IX_HOLD = 2;
	localparam int PBC_IX_HIST_LEN = 3;
	localparam int PBC_IX_FORCE_HOLD = 8;
	localparam int PBC_IX_SWITCH = 9;
	localparam int PBC_IX_MASKS = 10;
	localparam int PBC_IX_PRIO01 = 11;
	localparam int PBC_IX_PRIO23 = 12;
	localparam int PBC_IX_THR_LO = 14;
	localparam int PBC_IX_THR_HI = 15;
	localparam int PBC_IX_EXIT_BW0 = 25;
	localparam int PBC_EXIT_BW_REGS = 6;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int PBC_INSEL_REGCTRL_BIT = 0;
	localparam int PBC_INSEL_CHOICE_LSB = 1;
	localparam int PBC_FL_AUTO_BIT = 0;
	localparam int PBC_FL_MAN_BIT = 1;
	localparam int PBC_HOLD_EXIT_BW_BIT = 4;
	localparam int PBC_FORCE_HOLD_BIT = 0;
	localparam int PBC_PBO_BIT = 2;
	localparam int PBC_OOF_MASK_LSB = 4;
	localparam int PBC_PRIO_HI_LSB = 4;
	localparam int PBC_BW_APPLY_BIT = 0;
	localparam int PBC_ST_VALID_BIT = 1;
	localparam int PBC_ST_FASTLOCK_BIT = 2;
	localparam int PBC_ACTIVE_LSB = 6;

	// ----------------------------------------
	// Codes and timing
	// ----------------------------------------
	localparam logic [1:0] PBC_MODE_MANUAL = 2'h0;
	localparam logic [1:0] PBC_MODE_NONREV = 2'h1;
	localparam logic [1:0] PBC_MODE_REV = 2'h2;
	localparam logic [2:0] PBC_PRIO_BEST = 3'h1;
	localparam logic [2:0] PBC_PRIO_WORST = 3'h4;
	localparam int PBC_CLK_PERIOD_NS = 8;
	localparam int PBC_HIST_TICK_NS = 268;
	localparam int PBC_HIST_TICK_CYC = (PBC_HIST_TICK_NS + PBC_CLK_PERIOD_NS - 1) / PBC_CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		PBC_ST_TRACK = 2'b00,
		PBC_ST_HOLD = 2'b01,
		PBC_ST_FREERUN = 2'b10
	} pbc_state_t;

endpackage : pbc_pkg
